// ### design/tbs_pkg.sv
/*
  shared constants and types for the trigger bus self-test sequencer.
  assumes a single 20 MHz clock and an asynchronous active-low reset.
*/
package tbs_pkg;

  localparam int NUM_BUS   = 6;
  localparam int NUM_SENSE = 8;

  // clock and per-step dwell time
  localparam int CLK_MHZ   = 20;
  localparam int STEP_NS   = 1000;
  // least time, so round up to whole cycles
  localparam int STEP_CYC  = (STEP_NS * CLK_MHZ + 999) / 1000;

  // source and sense numbering, zero based
  localparam logic [2:0] SRC_EXT  = 3'h6;
  localparam logic [2:0] SRC_GET  = 3'h7;
  localparam logic [2:0] SRC_LAST = 3'h7;

  // position in the test sequence
  localparam logic [3:0] IDX_EXT   = 4'h6;
  localparam logic [3:0] IDX_GET   = 4'h7;
  localparam logic [3:0] IDX_SHORT = 4'h8;
  localparam logic [3:0] IDX_LAST  = 4'hf;

  // reported test numbers (minor part within group 105)
  localparam logic [4:0] ID_LOOP_OFS  = 5'h01;
  localparam logic [4:0] ID_SHORT_OFS = 5'h03;
  localparam logic [4:0] ID_EXT       = 5'h07;
  localparam logic [4:0] ID_GET       = 5'h08;
  localparam logic [4:0] ID_LAST      = 5'h12;

  // active level per sense input: bus lines and external trigger low
  localparam logic [7:0] SENSE_ACT_LOW = 8'h7f;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ARM     = 3'b001,
    ST_SCAN    = 3'b010,
    ST_ASSERT  = 3'b011,
    ST_RELEASE = 3'b100,
    ST_REPORT  = 3'b101
  } tbs_state_t;

endpackage : tbs_pkg

// ### design/tbs_self_test.sv
/*
  trigger bus self-test sequencer: loopback, external trigger isolation,
  GET detection and line-short tests, one result pulse per test.
  assumes pull-ups on the bus lines outside, and a bus controller that
  raises bus_get_in when get_req is seen.
*/
module tbs_self_test
  import tbs_pkg::*;
#(
  parameter int STEP_CYCLES = STEP_CYC
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               start,
  input  wire logic [NUM_BUS-1:0] trig_in,
  input  wire logic               ext_trig_in,
  input  wire logic               bus_get_in,
  output logic      [NUM_BUS-1:0] trig_out,
  output logic      [NUM_BUS-1:0] trig_oe_n,
  output logic                    meas_done_out,
  output logic                    get_req,
  output logic      [2:0]         sense_sel,
  output logic                    busy,
  output logic                    done,
  output logic                    result_valid,
  output logic      [4:0]         result_id,
  output logic                    result_pass,
  output logic                    short_flag
);

  tbs_state_t         state_q, state_d;
  logic [3:0]         test_q;
  logic [2:0]         src_q;
  logic [2:0]         sense_q;
  logic               trip_q;
  logic [NUM_BUS-1:0] oe_n_q;
  logic [NUM_BUS-1:0] out_q;
  logic               meas_q;
  logic               get_q;
  logic               busy_q;
  logic               done_q;
  logic               valid_q;
  logic [4:0]         id_q;
  logic               pass_q;
  logic               short_q;

  logic                 tick;
  logic [NUM_SENSE-1:0] trip_w;

  // sense vector in input order: bus lines, external trigger, GET
  wire [NUM_SENSE-1:0] sense_w = {bus_get_in, ext_trig_in, trig_in};

  tbs_trip_detect #(
    .N       (NUM_SENSE),
    .ACT_LOW (SENSE_ACT_LOW)
  ) u_det (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .sense   (sense_w),
    .trip    (trip_w)
  );

  tbs_step_timer #(
    .CYC     (STEP_CYCLES)
  ) u_tmr (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .run     (busy_q),
    .tick    (tick)
  );

  // test classification; sense input equals low bits of the index
  wire       loop_w     = (test_q < IDX_EXT);
  wire       get_w      = (test_q == IDX_GET);
  wire       short_w    = (test_q >= IDX_SHORT);
  wire [2:0] sense_nx_w = test_q[2:0];
  // loopback, ext and GET toggle the source matching the sense input;
  // shorts toggle every other source
  wire       use_src_w  = short_w ? (src_q != sense_q)
                                  : (src_q == sense_q);
  wire       expect_w   = loop_w || get_w;
  wire       hit_w      = trip_w[sense_q];
  wire       pass_w     = expect_w ? trip_q : !trip_q;
  wire [4:0] id_w       = short_w ? 5'(test_q) + ID_SHORT_OFS
                                  : 5'(test_q) + ID_LOOP_OFS;
  wire       last_src_w = (src_q == SRC_LAST);
  wire       on_w       = (state_d == ST_ASSERT);
  wire       on_bus_w   = on_w && (src_q < SRC_EXT);
  wire [NUM_BUS-1:0] oe_n_d = on_bus_w
                            ? ~(NUM_BUS'(1) << src_q)
                            : {NUM_BUS{1'b1}};
  wire       meas_d     = on_w && (src_q == SRC_EXT);
  wire       get_d      = (state_q == ST_SCAN) && use_src_w
                          && (src_q == SRC_GET);
  wire       report_w   = (state_q == ST_REPORT);
  wire       final_w    = report_w && (test_q == IDX_LAST);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:    if (start) state_d = ST_ARM;
      ST_ARM:     if (tick) state_d = ST_SCAN;
      ST_SCAN: begin
        if (use_src_w) state_d = ST_ASSERT;
        else if (last_src_w) state_d = ST_REPORT;
      end
      ST_ASSERT:  if (tick) state_d = ST_RELEASE;
      ST_RELEASE: begin
        if (tick) state_d = last_src_w ? ST_REPORT : ST_SCAN;
      end
      ST_REPORT:  state_d = (test_q == IDX_LAST) ? ST_IDLE : ST_ARM;
      default:    state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      test_q  <= '0;
      src_q   <= '0;
      sense_q <= '0;
      trip_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q == ST_IDLE && start) test_q <= '0;
      else if (report_w) test_q <= test_q + 4'h1;
      if (state_q == ST_ARM) begin
        sense_q <= sense_nx_w;
        src_q   <= '0;
      end else if ((state_q == ST_SCAN && !use_src_w && !last_src_w)
                   || (state_q == ST_RELEASE && tick && !last_src_w)) begin
        src_q   <= src_q + 3'h1;
      end
      // a trip in the clearing cycle still counts
      trip_q  <= (state_q == ST_ARM) ? hit_w : (trip_q || hit_w);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_n_q  <= {NUM_BUS{1'b1}};
      out_q   <= '0;
      meas_q  <= 1'b0;
      get_q   <= 1'b0;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      valid_q <= 1'b0;
      id_q    <= '0;
      pass_q  <= 1'b0;
      short_q <= 1'b0;
    end else begin
      // open drain: data stays low, only the enable moves
      oe_n_q  <= oe_n_d;
      out_q   <= '0;
      meas_q  <= meas_d;
      get_q   <= get_d;
      busy_q  <= (state_d != ST_IDLE);
      done_q  <= final_w;
      valid_q <= report_w;
      if (report_w) begin
        id_q   <= id_w;
        pass_q <= pass_w;
      end
      if (state_q == ST_IDLE && start) short_q <= 1'b0;
      else if (report_w && short_w && trip_q) short_q <= 1'b1;
    end
  end

  assign trig_out      = out_q;
  assign trig_oe_n     = oe_n_q;
  assign meas_done_out = meas_q;
  assign get_req       = get_q;
  assign sense_sel     = sense_q;
  assign busy          = busy_q;
  assign done          = done_q;
  assign result_valid  = valid_q;
  assign result_id     = id_q;
  assign result_pass   = pass_q;
  assign short_flag    = short_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  one_line_low_a: assert property (
    $onehot0(~oe_n_q) && ((&oe_n_q) || !meas_q))
    else $error("more than one trigger source driven");

  sense_set_a: assert property (
    (state_q == ST_ASSERT) |-> (sense_q == test_q[2:0]))
    else $error("source driven before sense input was selected");

  loop_pass_a: assert property (
    (report_w && loop_w) |=> (pass_q == $past(trip_q)))
    else $error("loopback result does not follow trip");

  loop_id_a: assert property (
    (report_w && loop_w) |=> (id_q == 5'($past(test_q)) + ID_LOOP_OFS))
    else $error("loopback test number wrong");

  ext_invert_a: assert property (
    (valid_q && id_q == ID_EXT) |-> (pass_q == !$past(trip_q)))
    else $error("external trigger pass sense not inverted");

  meas_src_a: assert property (
    $rose(meas_q) |-> (src_q == SRC_EXT) ##[1:STEP_CYCLES] !meas_q)
    else $error("meter complete pulse malformed");

  get_req_a: assert property (
    $rose(get_q) |-> (sense_q == SRC_GET || short_w) ##1 !get_q)
    else $error("GET request outside GET or shorts test");

  short_src_a: assert property (
    (state_q == ST_ASSERT && short_w) |-> (src_q != sense_q))
    else $error("shorts test drove its own sense source");

  short_flag_a: assert property (
    (report_w && short_w && trip_q) |=> (short_q && !pass_q))
    else $error("short not flagged");

  last_id_a: assert property (
    $rose(done_q) |-> (valid_q && id_q == ID_LAST))
    else $error("sequence did not end with last shorts test");

  one_result_a: assert property (
    valid_q |=> !valid_q)
    else $error("result pulse longer than one cycle");

  oe_drive_a: assert property (
    (state_q == ST_ASSERT && src_q < SRC_EXT)
    |-> !oe_n_q[src_q])
    else $error("selected bus line not pulled low");

  oe_idle_a: assert property (
    (state_q != ST_ASSERT)
    |-> (&oe_n_q))
    else $error("bus line pulled outside a drive step");

  sense_hold_a: assert property (
    (state_q != ST_ARM)
    |=> $stable(sense_q))
    else $error("sense input changed outside arming");

  trip_keep_a: assert property (
    (trip_q && state_q != ST_ARM)
    |=> trip_q)
    else $error("trip lost before the result");

  ext_quiet_a: assert property (
    (state_q == ST_ASSERT && test_q == IDX_EXT)
    |-> (meas_q && (&oe_n_q)))
    else $error("external trigger test drove a bus line");

  get_pass_a: assert property (
    (report_w && get_w)
    |=> (pass_q == $past(trip_q)))
    else $error("GET result does not follow trip");

  get_src_a: assert property (
    get_q
    |-> (state_q == ST_ASSERT && src_q == SRC_GET))
    else $error("GET request outside its drive step");

  meas_only_a: assert property (
    meas_q
    |-> (state_q == ST_ASSERT && src_q == SRC_EXT))
    else $error("meter complete outside its drive step");

  src_step_a: assert property (
    (state_q != ST_ARM)
    |=> (src_q == $past(src_q) || src_q == $past(src_q) + 3'h1))
    else $error("sources not taken in ascending order");

  short_pass_a: assert property (
    (report_w && short_w && !trip_q)
    |=> pass_q)
    else $error("clean shorts test not passed");

  result_hold_a: assert property (
    !report_w
    |=> ($stable(id_q) && $stable(pass_q)))
    else $error("result changed without a finished test");

  cov_loop_pass_c:  cover property (valid_q && id_q == ID_LOOP_OFS && pass_q);
  cov_ext_fail_c:   cover property (valid_q && id_q == ID_EXT && !pass_q);
  cov_get_pass_c:   cover property (valid_q && id_q == ID_GET && pass_q);
  cov_short_c:      cover property ($rose(short_q));
  cov_done_c:       cover property (done_q);

endmodule : tbs_self_test

// ### design/tbs_step_timer.sv
/*
  step timer: one-cycle tick every CYC cycles while run is high.
  assumes the same clock and reset as the sequencer.
*/
module tbs_step_timer #(
  parameter int CYC = 20
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic run,
  output logic      tick
);
  localparam int W = $clog2(CYC + 1);
  localparam logic [W-1:0] LAST = W'(CYC - 1);

  logic [W-1:0] cnt_q;
  logic         tick_q;
  wire          wrap_w = (cnt_q == LAST);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= (!run || wrap_w) ? '0 : cnt_q + W'(1);
      tick_q <= run && wrap_w;
    end
  end

  assign tick = tick_q;

endmodule : tbs_step_timer

// ### design/tbs_trip_detect.sv
/*
  trip detectors: one-cycle pulse when a sense input enters its active level.
  assumes inputs already synchronous to ref_clk.
*/
module tbs_trip_detect #(
  parameter int         N       = 8,
  parameter logic [7:0] ACT_LOW = 8'h7f
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] sense,
  output logic      [N-1:0] trip
);
  logic [N-1:0] act_q;
  logic [N-1:0] trip_q;

  for (genvar i = 0; i < N; i++) begin : g_det
    wire act_w = sense[i] ^ ACT_LOW[i];
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        act_q[i]  <= 1'b0;
        trip_q[i] <= 1'b0;
      end else begin
        act_q[i]  <= act_w;
        trip_q[i] <= act_w && !act_q[i];
      end
    end
  end

  assign trip = trip_q;

endmodule : tbs_trip_detect

// ### verification/tbs_bus_far_side.sv
/*
  far side of the trigger bus: pulled-up bus lines, the external trigger
  path and the bus controller's GET strobe, each with a fault switch.
  assumes the sequencer's ports and its single clock.
*/
module tbs_bus_far_side (
  input  wire logic       ref_clk,
  input  wire logic [5:0] trig_out,
  input  wire logic [5:0] trig_oe_n,
  input  wire logic       meas_done_out,
  input  wire logic       get_req,
  input  wire logic       short_12,
  input  wire logic       short_ext,
  input  wire logic       get_dead,
  output logic      [5:0] trig_in,
  output logic            ext_trig_in,
  output logic            bus_get_in
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [5:0] pulled;

  // a line reads low while any switch on it is on, else the pull-up wins
  assign pulled = ~trig_oe_n & ~trig_out;

  always_comb begin
    trig_in = ~pulled;
    if (short_12) begin
      trig_in[0] = ~(pulled[0] | pulled[1]);
      trig_in[1] = ~(pulled[0] | pulled[1]);
    end
  end

  // no path from meter complete unless the fault is wired in
  assign ext_trig_in = short_ext ? ~meas_done_out : 1'b1;

  // controller answers a request one cycle later with a single strobe
  always_ff @(posedge ref_clk) begin
    bus_get_in <= get_req & ~get_dead;
  end
endmodule : tbs_bus_far_side

// ### verification/trigger_bus_self_test_test.sv
/*
  self-checking bench for the trigger bus self-test sequencer.
  assumes the far side model; step time shortened to 3 cycles.
*/
module trigger_bus_self_test_test;
  timeunit 1ns;
  timeprecision 1ps;
  import tbs_pkg::*;

  localparam int STEP = 3;

  logic       ref_clk   = 1'b0;
  logic       rst_n     = 1'b0;
  logic       start     = 1'b0;
  logic       short_12  = 1'b0;
  logic       short_ext = 1'b0;
  logic       get_dead  = 1'b0;
  logic [5:0] trig_in, trig_out, trig_oe_n;
  logic       ext_trig_in, bus_get_in, meas_done_out, get_req;
  logic [2:0] sense_sel;
  logic       busy, done, result_valid, result_pass, short_flag;
  logic [4:0] result_id;
  int         miscompares = 0;
  int         num_checks  = 0;

  always #25 ref_clk = ~ref_clk;

  tbs_self_test #(.STEP_CYCLES(STEP)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .start(start), .trig_in(trig_in),
    .ext_trig_in(ext_trig_in), .bus_get_in(bus_get_in),
    .trig_out(trig_out), .trig_oe_n(trig_oe_n),
    .meas_done_out(meas_done_out), .get_req(get_req),
    .sense_sel(sense_sel), .busy(busy), .done(done),
    .result_valid(result_valid), .result_id(result_id),
    .result_pass(result_pass), .short_flag(short_flag));

  tbs_bus_far_side far (
    .ref_clk(ref_clk), .trig_out(trig_out), .trig_oe_n(trig_oe_n),
    .meas_done_out(meas_done_out), .get_req(get_req),
    .short_12(short_12), .short_ext(short_ext), .get_dead(get_dead),
    .trig_in(trig_in), .ext_trig_in(ext_trig_in),
    .bus_get_in(bus_get_in));

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // one full sequence; bit k of fail_mask set means test k must fail
  task automatic run_seq(input logic [15:0] fail_mask,
                         input logic        exp_short);
    int         k;
    int         n;
    logic [7:0] seen;
    logic [7:0] want;
    logic [4:0] id_exp;
    logic [5:0] od;
    k = 0;
    seen = 8'h00;
    od = 6'h00;
    start = 1'b1;
    for (n = 0; n < 4000 && k < 16; n++) begin
      @(posedge ref_clk);
      #1;
      // a second start while busy must not restart anything
      start = (n == 6);
      seen = seen | {get_req, meas_done_out, ~trig_oe_n};
      od = od | trig_out;
      if (n == 6) begin
        check("busy", 16'(busy), 16'h0001);
      end
      if (result_valid === 1'b1) begin
        want = (k < 8) ? 8'h01 << k : ~(8'h01 << (k - 8));
        id_exp = (k < 8) ? 5'(k + 1) : 5'(k + 3);
        check("sources", 16'(seen), 16'(want));
        check("result_id", 16'(result_id), 16'(id_exp));
        check("result_pass", 16'(result_pass),
              16'(!fail_mask[k]));
        check("done", 16'(done), 16'(k == 15));
        check("sense_sel", 16'(sense_sel), 16'(k[2:0]));
        seen = 8'h00;
        k++;
      end
    end
    if (k < 16) begin
      check("results", 16'(k), 16'h0010);
      give_verdict();
    end
    check("short_flag", 16'(short_flag), 16'(exp_short));
    check("trig_out", 16'(od), 16'h0000);
    for (n = 0; n < 10; n++) begin
      @(posedge ref_clk);
      #1;
      seen[0] = seen[0] | result_valid;
    end
    check("idle after run", 16'({busy, seen[0]}), 16'h0000);
  endtask : run_seq

  task automatic idle_after_reset();
    check("idle outputs", 16'({trig_oe_n, meas_done_out, busy}),
          16'h00fc);
    check("idle trig_out", 16'(trig_out), 16'h0000);
  endtask : idle_after_reset

  task automatic healthy_run();
    run_seq(16'h0000, 1'b0);
  endtask : healthy_run

  task automatic line_short_run();
    short_12 = 1'b1;
    run_seq(16'h0300, 1'b1);
    short_12 = 1'b0;
  endtask : line_short_run

  // also proves short_flag is cleared by the next start
  task automatic ext_short_run();
    short_ext = 1'b1;
    run_seq(16'h0040, 1'b0);
    short_ext = 1'b0;
  endtask : ext_short_run

  task automatic get_missing_run();
    get_dead = 1'b1;
    run_seq(16'h0080, 1'b0);
    get_dead = 1'b0;
  endtask : get_missing_run

  initial begin
    repeat (2) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    idle_after_reset();
    healthy_run();
    line_short_run();
    ext_short_run();
    get_missing_run();
    give_verdict();
  end
endmodule : trigger_bus_self_test_test
